// *** src/cpcpc_top.sv ***
// Purpose: CPU clock divider and sleep/halt power-mode controller
// Assumes: aclk stands for the undivided system clock
// Notes:   Wake edges are sampled on aclk and synchronised
// Operation
// - Read-only revision register, increments per silicon
// - CPU clock is system clock over field+1
// - Divisor slows only the processor clock
// - Power register selects sleep or halt, wake enables
// - Bits 15..12 wake on USB port transitions
// - Bit 11 wakes on OTG valid/ID change
// - Bit 9 fast serial wake, byte discarded
// - Bit 8 select falling edge wakes, byte discarded
// - Bit 7 wakes on parallel host port read
// - Bit 4 wakes on pins 24/25 transitions
// - Bit 2 reads rail low status
// - Writing one to bit 1 enters sleep
// - Counters and PWM freeze during sleep
// - Enabled activity ends sleep, resume within 0.5 ms
// - Sender resends the byte lost at wakeup
// - Bit 0 halts CPU until enabled interrupt
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module cpcpc_top
    import cpcpc_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [17:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [17:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Wake sources
    input  wire logic [3:0]  usb_port_line,
    input  wire logic        otg_vbus_valid,
    input  wire logic        otg_id,
    input  wire logic        fast_serial_link,
    input  wire logic        serial_select_low,
    input  wire logic        parallel_host_port_read,
    input  wire logic [1:0]  gpio_wake_pin,
    input  wire logic        rail_low_status,
    input  wire logic        cpu_irq_pending,
    // Power and clock outputs
    output logic             cpu_clk_en,
    output logic             cpu_halted,
    output logic             sys_clk_run,
    output logic             periph_freeze,
    output logic             analog_power_down,
    output logic             rx_byte_discard,
    output logic             cpu_exec_ok,
    output logic             irq
);

    // Registers
    logic [3:0]   div_field;      // CPU speed divisor
    logic [3:0]   div_count;      // Divider phase counter
    logic [15:0]  pwr_enables;    // Wake enable bits
    logic [2:0]   evt_status;     // Sticky events
    logic [2:0]   evt_mask;       // Event mask
    cpcpc_state_t state;          // Power state
    logic [15:0]  resume_cnt;     // Resume delay counter
    logic [9:0]   wake_prev;      // Previous wake levels
    logic [1:0]   gpio_prev;      // Previous pin levels
    logic         wake_sync1;     // Synchroniser stage 1
    logic         wake_sync2;     // Synchroniser stage 2
    logic         discard_arm;    // Discard byte after any sleep wake
    // Bus holding state
    logic         aw_held;
    logic         w_held;
    logic [17:0]  aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;

    // Wake source vector: usb[3:0], otg vbus, otg id, fsl, ssel, host, pins
    logic [9:0]   wake_now;
    assign wake_now = {usb_port_line, otg_vbus_valid, otg_id, fast_serial_link,
                       serial_select_low, parallel_host_port_read, gpio_wake_pin[0] ^ gpio_wake_pin[1]};

    // Per-source activity: changes, select falling edge, host read as a level
    wire  [9:0]   wake_change = wake_now ^ wake_prev;
    wire  [3:0]   usb_hit     = wake_change[9:6] & pwr_enables[PB_USB_LO +: 4];
    wire          otg_hit     = (|wake_change[5:4]) & pwr_enables[PB_OTG];
    wire          fsl_hit     = wake_change[3] & pwr_enables[PB_FSL];
    wire          spi_hit     = wake_change[2] & ~wake_now[2] & pwr_enables[PB_SPI];
    wire          host_hit    = wake_now[1] & pwr_enables[PB_HOST];
    wire          pin_hit     = (|(gpio_wake_pin ^ gpio_prev)) & pwr_enables[PB_PIN];
    wire          wake_raw    = (|usb_hit) | otg_hit | fsl_hit | spi_hit | host_hit | pin_hit;

    // Bus decode
    wire          wr_go       = aw_held & w_held & ~s_axi_bvalid;
    wire          rd_go       = s_axi_arvalid & s_axi_arready;
    wire          wr_div      = wr_go & (aw_addr == DIV_ADDR) & w_strb[0];
    wire          wr_pwr_lo   = wr_go & (aw_addr == PWR_ADDR) & w_strb[0];
    wire          wr_pwr_hi   = wr_go & (aw_addr == PWR_ADDR) & w_strb[1];
    wire          wr_stat     = wr_go & (aw_addr == STAT_ADDR) & w_strb[0];
    wire          wr_mask     = wr_go & (aw_addr == MASK_ADDR) & w_strb[0];
    wire          wr_known    = (aw_addr == REV_ADDR) | (aw_addr == DIV_ADDR) | (aw_addr == PWR_ADDR) |
                                (aw_addr == STAT_ADDR) | (aw_addr == MASK_ADDR) | (aw_addr == WAKEIN_ADDR);
    wire          enter_sleep = wr_pwr_lo & w_data[PB_SLEEP] & (state == CPCPC_RUN);
    wire          enter_halt  = wr_pwr_lo & w_data[PB_HALT] & ~w_data[PB_SLEEP] & (state == CPCPC_RUN);
    wire          cpu_stop    = enter_sleep | enter_halt;
    wire          halt_wake   = (state == CPCPC_HALT) & cpu_irq_pending;
    wire          sleep_wake  = (state == CPCPC_SLEEP) & wake_sync2;
    wire          resume_done = (state == CPCPC_RESUME) & (resume_cnt == 16'h0000);
    wire          div_tick    = (div_count == div_field);
    // Live power register view
    wire  [15:0]  pwr_view    = (pwr_enables & PWR_WMASK) | ({15'h0000, rail_low_status} << PB_RAIL) |
                                ({15'h0000, state == CPCPC_SLEEP} << PB_SLEEP) |
                                ({15'h0000, state == CPCPC_HALT} << PB_HALT);
    wire  [2:0]   evt_set     = {rail_low_status, halt_wake, resume_done};
    wire  [15:0]  next_pwr    = {wr_pwr_hi ? w_data[15:8] : pwr_enables[15:8],
                                 wr_pwr_lo ? w_data[7:0] : pwr_enables[7:0]} & PWR_WMASK;
    logic [31:0]  rd_mux;
    always_comb begin
        // Read data select
        case (s_axi_araddr)
            REV_ADDR:    rd_mux = {16'h0000, REV_DEFAULT};
            DIV_ADDR:    rd_mux = {28'h0000000, div_field};
            PWR_ADDR:    rd_mux = {16'h0000, pwr_view};
            STAT_ADDR:   rd_mux = {29'h00000000, evt_status};
            MASK_ADDR:   rd_mux = {29'h00000000, evt_mask};
            WAKEIN_ADDR: rd_mux = {22'h000000, wake_now};
            default:     rd_mux = 32'h00000000;
        endcase
    end
    wire          rd_known    = (s_axi_araddr == REV_ADDR) | (s_axi_araddr == DIV_ADDR) |
                                (s_axi_araddr == PWR_ADDR) | (s_axi_araddr == STAT_ADDR) |
                                (s_axi_araddr == MASK_ADDR) | (s_axi_araddr == WAKEIN_ADDR);

    // Write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 18'h00000;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_field   <= DIV_RESET;
            pwr_enables <= 16'h0000;
            evt_mask    <= 3'h0;
        end else begin
            if (wr_div) begin
                div_field <= w_data[3:0] & DIV_MASK[3:0];
            end
            pwr_enables <= next_pwr;
            if (wr_mask) begin
                evt_mask <= w_data[2:0] & ST_MASK;
            end
        end
    end

    // Sticky events, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_status <= 3'h0;
        end else begin
            evt_status <= (evt_status & ~(wr_stat ? w_data[2:0] : 3'h0)) | evt_set;
        end
    end

    // Wake edge capture; aclk stands in for the restart oscillator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_prev  <= 10'h000;
            gpio_prev  <= 2'b00;
            wake_sync1 <= 1'b0;
            wake_sync2 <= 1'b0;
        end else begin
            wake_prev  <= wake_now;
            gpio_prev  <= gpio_wake_pin;
            wake_sync1 <= wake_raw & (state == CPCPC_SLEEP);
            wake_sync2 <= wake_sync1;
        end
    end

    // Power state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= CPCPC_RUN;
            resume_cnt  <= 16'h0000;
            discard_arm <= 1'b0;
        end else begin
            case (state)
                CPCPC_RUN: begin
                    if (enter_sleep) begin
                        state <= CPCPC_SLEEP;
                    end else if (enter_halt) begin
                        state <= CPCPC_HALT;
                    end
                end
                CPCPC_HALT: begin
                    if (halt_wake) begin
                        state <= CPCPC_RUN;
                    end
                end
                CPCPC_SLEEP: begin
                    if (sleep_wake) begin
                        state       <= CPCPC_RESUME;
                        resume_cnt  <= 16'(RESUME_CYC - 1);
                        discard_arm <= 1'b1;
                    end
                end
                CPCPC_RESUME: begin
                    if (resume_cnt != 16'h0000) begin
                        resume_cnt <= resume_cnt - 16'h0001;
                    end else begin
                        state       <= CPCPC_RUN;
                        discard_arm <= 1'b0;
                    end
                end
                default: state <= CPCPC_RUN;
            endcase
        end
    end

    // Divider phase, paused in sleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_count <= 4'h0;
        end else if (state == CPCPC_SLEEP) begin
            div_count <= div_count;
        end else if (div_tick) begin
            div_count <= 4'h0;
        end else begin
            div_count <= div_count + 4'h1;
        end
    end

    // Registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clk_en        <= 1'b0;
            cpu_halted        <= 1'b0;
            sys_clk_run       <= 1'b1;
            periph_freeze     <= 1'b0;
            analog_power_down <= 1'b0;
            rx_byte_discard   <= 1'b0;
            cpu_exec_ok       <= 1'b1;
            irq               <= 1'b0;
        end else begin
            cpu_clk_en        <= div_tick & (state == CPCPC_RUN);
            cpu_halted        <= (state != CPCPC_RUN) | cpu_stop;
            sys_clk_run       <= (state != CPCPC_SLEEP) & ~enter_sleep;
            periph_freeze     <= (state == CPCPC_SLEEP) | enter_sleep;
            analog_power_down <= (state == CPCPC_SLEEP) | enter_sleep;
            rx_byte_discard   <= discard_arm | sleep_wake;
            cpu_exec_ok       <= (state == CPCPC_RUN) & ~cpu_stop;
            irq               <= |(evt_status & evt_mask);
        end
    end

endmodule

// *** src/cpcpc_pkg.sv ***
// Purpose: Constants for the processor clock and power-mode controller
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes:   Register offsets and field positions live here only
package cpcpc_pkg;
    // Register byte offsets (printed offsets are not all multiples of four)
    localparam logic [15:0] REV_IDX      = 16'hc004; // Revision register index
    localparam logic [15:0] DIV_IDX      = 16'hc008; // Divisor register index
    localparam logic [15:0] PWR_IDX      = 16'hc00a; // Power register index
    localparam logic [17:0] REV_ADDR     = {REV_IDX, 2'b00};
    localparam logic [17:0] DIV_ADDR     = {DIV_IDX, 2'b00};
    localparam logic [17:0] PWR_ADDR     = {PWR_IDX, 2'b00};
    localparam logic [17:0] STAT_ADDR    = 18'h30100; // Event status
    localparam logic [17:0] MASK_ADDR    = 18'h30104; // Event mask
    localparam logic [17:0] WAKEIN_ADDR  = 18'h30108; // Live wake-source levels
    // Revision value: arbitrary neutral value
    localparam logic [15:0] REV_DEFAULT  = 16'h0a01;
    // Divisor field
    localparam logic [3:0]  DIV_RESET    = 4'hf;
    localparam logic [15:0] DIV_MASK     = 16'h000f;
    // Power register fields
    localparam int          PB_HALT      = 0;
    localparam int          PB_SLEEP     = 1;
    localparam int          PB_RAIL      = 2;
    localparam int          PB_PIN       = 4;
    localparam int          PB_HOST      = 7;
    localparam int          PB_SPI       = 8;
    localparam int          PB_FSL       = 9;
    localparam int          PB_OTG       = 11;
    localparam int          PB_USB_LO    = 12;
    localparam logic [15:0] PWR_WMASK    = 16'hfb90; // Writable enable bits
    // Status bits
    localparam int          ST_SLEEP_END = 0;
    localparam int          ST_HALT_END  = 1;
    localparam int          ST_RAIL      = 2;
    localparam logic [2:0]  ST_MASK      = 3'h7;
    // Timing
    localparam int          CLK_HZ       = 20000000;
    localparam real         RESUME_MS    = 0.5;
    localparam int          RESUME_CYC   = int'($floor(RESUME_MS * CLK_HZ / 1000.0));
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
    // Power states
    typedef enum logic [1:0] {
        CPCPC_RUN    = 2'b00,
        CPCPC_HALT   = 2'b01,
        CPCPC_SLEEP  = 2'b10,
        CPCPC_RESUME = 2'b11
    } cpcpc_state_t;
endpackage

// *** testbench/cpcpc_top_asserts.sv ***
// Purpose: Concurrent checks on the power controller ports
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Resume length is tracked by a helper counter
`timescale 1ns/1ps
module cpcpc_top_asserts
    import cpcpc_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Power outputs
    input wire logic        cpu_clk_en,
    input wire logic        cpu_halted,
    input wire logic        sys_clk_run,
    input wire logic        periph_freeze,
    input wire logic        analog_power_down,
    input wire logic        rx_byte_discard,
    input wire logic        cpu_exec_ok
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] resume_cnt; // Cycles spent discarding after wake
    // Count resume cycles, cleared outside resume
    always_ff @(posedge aclk) begin
        if (!aresetn || !rx_byte_discard)
            resume_cnt <= 16'h0000;
        else
            resume_cnt <= resume_cnt + 16'h0001;
    end
    chk_sleep_power: assert property (!sys_clk_run |-> periph_freeze && analog_power_down && cpu_halted)
        else $error("sleep without full power down");
    chk_halt_clock: assert property (cpu_halted && !periph_freeze |-> sys_clk_run && !analog_power_down)
        else $error("halt stopped the system clock");
    chk_halt_cpuclk: assert property (cpu_halted && $past(cpu_halted) |-> !cpu_clk_en)
        else $error("processor clock enable while halted");
    chk_exec_halt: assert property (cpu_exec_ok |-> !cpu_halted)
        else $error("execution while halted");
    chk_discard_exec: assert property (rx_byte_discard |-> !cpu_exec_ok)
        else $error("execution before resume ended");
    chk_wake_discard: assert property ($fell(periph_freeze) |-> ##[0:2] rx_byte_discard)
        else $error("sleep ended without discard");
    chk_discard_origin: assert property ($rose(rx_byte_discard) |-> periph_freeze || $past(periph_freeze))
        else $error("discard without preceding sleep");
    chk_resume_bound: assert property (resume_cnt <= RESUME_CYC + 4)
        else $error("resume longer than allowed");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready longer than one cycle");
    // Main scenarios
    cover property ($fell(periph_freeze));
    cover property ($rose(cpu_halted) && sys_clk_run);
    cover property ($fell(rx_byte_discard) ##1 cpu_exec_ok);
endmodule

bind cpcpc_top cpcpc_top_asserts cpcpc_top_asserts_i (
    .aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cpu_clk_en, .cpu_halted, .sys_clk_run,
    .periph_freeze, .analog_power_down, .rx_byte_discard, .cpu_exec_ok
);

// *** testbench/tb_cpu_clock_power_control.sv ***
// Purpose: Self-checking bench for the clock and power-mode controller
// Assumes: aclk 20 MHz, bench drives all ports itself
// Notes:   Each wake costs the fixed resume time, so few wakes
`timescale 1ns/1ps
module tb_cpu_clock_power_control
    import cpcpc_pkg::*;
();
    typedef struct packed {logic wr; logic [17:0] addr; logic [31:0] wdata; logic [31:0] exp; logic [1:0] resp;} cpcpc_row_t;
    // Bus stimulus
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    // Wake sources and status inputs
    logic [3:0]  usb_port_line = 4'h0;
    logic [1:0]  gpio_wake_pin = 2'h0;
    logic        otg_vbus_valid = 1'b0, otg_id = 1'b0, fast_serial_link = 1'b0;
    logic        serial_select_low = 1'b1, parallel_host_port_read = 1'b0;
    logic        rail_low_status = 1'b0, cpu_irq_pending = 1'b0;
    // Design outputs
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        cpu_clk_en, cpu_halted, sys_clk_run, periph_freeze;
    logic        analog_power_down, rx_byte_discard, cpu_exec_ok, irq;
    int          errors = 0, checked = 0;
    // Register rows: reserved bits always written as zero
    cpcpc_row_t  rows[15] = '{
        '{1'b0, REV_ADDR, 32'h0, {16'h0, REV_DEFAULT}, RESP_OKAY}, '{1'b0, DIV_ADDR, 32'h0, 32'hf, RESP_OKAY},
        '{1'b0, PWR_ADDR, 32'h0, 32'h0, RESP_OKAY}, '{1'b0, STAT_ADDR, 32'h0, 32'h0, RESP_OKAY},
        '{1'b0, MASK_ADDR, 32'h0, 32'h0, RESP_OKAY}, '{1'b1, DIV_ADDR, 32'h0, 32'h0, RESP_OKAY},
        '{1'b1, DIV_ADDR, 32'h9, 32'h9, RESP_OKAY}, '{1'b1, PWR_ADDR, 32'hfb90, 32'hfb90, RESP_OKAY},
        '{1'b1, PWR_ADDR, 32'h0, 32'h0, RESP_OKAY}, '{1'b1, REV_ADDR, 32'h1234, {16'h0, REV_DEFAULT}, RESP_OKAY},
        '{1'b1, MASK_ADDR, 32'h7, 32'h7, RESP_OKAY}, '{1'b1, MASK_ADDR, 32'h0, 32'h0, RESP_OKAY},
        '{1'b1, 18'h00008, 32'h0, 32'h0, RESP_SLVERR}, '{1'b0, 18'h00004, 32'h0, 32'h0, RESP_SLVERR},
        '{1'b0, WAKEIN_ADDR, 32'h0, 32'h4, RESP_OKAY}};
    logic [31:0] divs[3] = '{32'h0, 32'h2, 32'hf}; // Divisor settings to time
    int          wbit[7] = '{15, 12, 11, 9, 8, 7, 4}; // Wake enable per source

    cpcpc_top cpcpc_top_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .usb_port_line, .otg_vbus_valid, .otg_id, .fast_serial_link, .serial_select_low,
        .parallel_host_port_read, .gpio_wake_pin, .rail_low_status, .cpu_irq_pending, .cpu_clk_en,
        .cpu_halted, .sys_clk_run, .periph_freeze, .analog_power_down, .rx_byte_discard, .cpu_exec_ok, .irq
    );
    // 50 ns clock
    always #25 aclk = ~aclk;

    task automatic close_out();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("FAIL %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("FAIL %0t flag %b expected %b", $time, g, e);
        end
    endtask
    // Step past an edge so its updates have landed
    task automatic tick();
        @(posedge aclk);
        #1;
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic axw(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        r = 2'b11;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h3;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 60 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                done = 1'b1;
                r = s_axi_bresp;
            end
        end
        s_axi_bready <= 1'b0;
        if (!done) begin
            errors++;
            $display("FAIL %0t write hang", $time);
            close_out();
        end
    endtask
    // Read: address held until taken, data taken with rvalid
    task automatic axr(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        r = 2'b11;
        d = 32'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 60 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                done = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
            end
        end
        s_axi_rready <= 1'b0;
        if (!done) begin
            errors++;
            $display("FAIL %0t read hang", $time);
            close_out();
        end
    endtask

    initial begin
        int n;
        logic [31:0] d;
        logic [1:0] r;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // Register table
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axw(rows[i].addr, rows[i].wdata, r);
                cmp32({30'h0, r}, {30'h0, rows[i].resp});
            end
            axr(rows[i].addr, d, r);
            cmp32(d, rows[i].exp);
            cmp32({30'h0, r}, {30'h0, rows[i].resp});
        end
        $display("test register table done");
        // Processor clock period for each divisor
        foreach (divs[j]) begin
            axw(DIV_ADDR, divs[j], r);
            repeat (20) tick();
            for (n = 0; n < 40 && cpu_clk_en !== 1'b1; n++) tick();
            tick();
            for (n = 1; n < 40 && cpu_clk_en !== 1'b1; n++) tick();
            cmp32(n, divs[j] + 32'h1);
            cmp1(sys_clk_run & ~periph_freeze, 1'b1);
        end
        $display("test divider done");
        // Sleep and wake through seven sources, with disabled USB port 1 ignored
        for (int k = 0; k < 7; k++) begin
            axw(PWR_ADDR, (32'h1 << wbit[k]) | (32'h1 << PB_SLEEP), r);
            repeat (3) tick();
            cmp1(sys_clk_run, 1'b0);
            cmp1(periph_freeze & analog_power_down, 1'b1);
            @(posedge aclk);
            usb_port_line[1] <= ~usb_port_line[1];
            repeat (6) tick();
            cmp1(sys_clk_run, 1'b0);
            @(posedge aclk);
            case (k)
                0: usb_port_line[3] <= ~usb_port_line[3];
                1: usb_port_line[0] <= ~usb_port_line[0];
                2: otg_vbus_valid <= ~otg_vbus_valid;
                3: fast_serial_link <= ~fast_serial_link;
                4: serial_select_low <= 1'b0;
                5: parallel_host_port_read <= 1'b1;
                default: gpio_wake_pin[0] <= ~gpio_wake_pin[0];
            endcase
            for (n = 0; n < 20 && rx_byte_discard !== 1'b1; n++) tick();
            cmp1(rx_byte_discard, 1'b1);
            @(posedge aclk);
            parallel_host_port_read <= 1'b0;
            serial_select_low <= 1'b1;
            for (n = 0; n < RESUME_CYC + 50 && cpu_exec_ok !== 1'b1; n++) tick();
            cmp1(cpu_exec_ok, 1'b1);
            cmp1(n <= RESUME_CYC, 1'b1);
        end
        $display("test sleep wake done");
        // Sticky status, mask and clear
        cmp1(irq, 1'b0);
        axw(MASK_ADDR, 32'h1, r);
        repeat (3) tick();
        cmp1(irq, 1'b1);
        axw(STAT_ADDR, 32'h7, r);
        repeat (3) tick();
        cmp1(irq, 1'b0);
        $display("test interrupt done");
        // Halt keeps clocks, ends on interrupt
        axw(PWR_ADDR, 32'h1 << PB_HALT, r);
        repeat (3) tick();
        cmp1(cpu_halted & sys_clk_run & ~periph_freeze & ~cpu_exec_ok, 1'b1);
        @(posedge aclk);
        cpu_irq_pending <= 1'b1;
        for (n = 0; n < 20 && cpu_exec_ok !== 1'b1; n++) tick();
        cmp1(cpu_exec_ok, 1'b1);
        @(posedge aclk);
        cpu_irq_pending <= 1'b0;
        axr(STAT_ADDR, d, r);
        cmp32(d & 32'h2, 32'h2);
        $display("test halt done");
        // Rail status read back
        @(posedge aclk);
        rail_low_status <= 1'b1;
        repeat (3) tick();
        axr(PWR_ADDR, d, r);
        cmp32(d, 32'h4);
        $display("test rail done");
        // Second reset restores defaults
        @(posedge aclk);
        aresetn <= 1'b0;
        rail_low_status <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axr(DIV_ADDR, d, r);
        cmp32(d, {28'h0, DIV_RESET});
        cmp1(cpu_exec_ok & ~irq, 1'b1);
        $display("test reset done");
        close_out();
    end
endmodule
